//--- src/tss_fault_defs.svh
/*
 * Constants for the task-state validation fault unit: register offsets,
 * field positions, reset values, descriptor type codes, vectors and limits.
 * Assumes inclusion by the package, the unit and the bench.
 */
`ifndef TSS_FAULT_DEFS_SVH
`define TSS_FAULT_DEFS_SVH

`define REG_CTRL_OFS       32'h0000_0000
`define REG_STATUS_OFS     32'h0000_0004
`define REG_COUNT_OFS      32'h0000_0008
`define CTRL_EN_BIT        0
`define CTRL_RST           32'h0000_0001

`define VEC_INVALID_TASK   8'h0A
`define VEC_GEN_PROT       8'h0D
`define TSS32_MIN_LIMIT    32'h0000_0067
`define TSS16_MIN_LIMIT    32'h0000_002C

`define TYPE_AVAIL_16      4'h1
`define TYPE_LDT           4'h2
`define TYPE_BUSY_16       4'h3
`define TYPE_AVAIL_32      4'h9
`define TYPE_BUSY_32       4'hB
`define UPPER_TYPE_OK      5'h00

`define SEG_LDT            3'h0
`define SEG_STACK          3'h1
`define SEG_CODE           3'h2

`endif

//--- src/tss_fault_pkg.sv
/*
 * Types for the task-state validation fault unit.
 * Assumes the constants header sits beside it.
 */
`include "tss_fault_defs.svh"

package tss_fault_pkg;

    typedef enum logic [2:0] {
        OP_LOAD_TR, OP_JUMP, OP_CALL, OP_EXCEPTION, OP_NESTED_RET, OP_PRIV_CALL
    } task_op_t;

    // one segment register image as loaded from the task segment
    typedef struct packed {
        logic [15:0] sel;
        logic        s;
        logic [3:0]  typ;
        logic [1:0]  descriptor_privilege;
        logic        present;
        logic [31:0] table_limit;
    } seg_desc_t;

    typedef struct packed {
        task_op_t    op;
        logic        outside_event;
        logic        long_mode;
        logic [15:0] tss_sel;
        logic [31:0] tss_limit;
        logic [3:0]  tss_type;
        logic [4:0]  upper_type;
        logic        base_canonical;
        logic [31:0] gdt_limit;
        logic        new_desc_wr;
        logic        old_desc_wr;
        logic        link_wr;
        logic        old_store_fault;
        logic        link_load_fault;
        logic        stack_load_fault;
    } task_req_t;

    typedef struct packed {
        logic [7:0]  vector;
        logic [15:0] err_code;
        logic        new_ctx;
        logic        restartable;
    } fault_rec_t;

endpackage : tss_fault_pkg

//--- src/tss_fault_unit.sv
/*
 * Task-state validation fault unit: checks task segment, local table and
 * segment selectors on switches, task register loads and privilege calls.
 * Assumes request data from core logic on the same clock, and an AHB-Lite
 * master for the control and status registers.
 */
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tss_fault_defs.svh"

module tss_fault_unit #(
    parameter int NUM_DATA = 4
) (
    // clock and reset
    input  wire logic                            clock_i,
    input  wire logic                            sys_rst_i,
    // request from the switch sequencer
    input  wire logic                            req_valid_i,
    input  wire tss_fault_pkg::task_req_t        req_i,
    input  wire tss_fault_pkg::seg_desc_t [NUM_DATA+2:0] segs_i,
    input  wire logic                            overrun_i,
    output logic                                 busy_o,
    output logic                                 done_o,
    // sequencing towards the core
    output logic                                 tr_load_o,
    output logic                                 link_write_o,
    output logic                                 seg_load_o,
    output logic [2:0]                           seg_idx_o,
    // towards exception dispatch
    output logic                                 fault_valid_o,
    output tss_fault_pkg::fault_rec_t            fault_o,
    // AHB-Lite slave
    input  wire logic                            hsel_i,
    input  wire logic [31:0]                     haddr_i,
    input  wire logic [1:0]                      htrans_i,
    input  wire logic                            hwrite_i,
    input  wire logic [2:0]                      hsize_i,
    input  wire logic [31:0]                     hwdata_i,
    input  wire logic                            hready_i,
    output logic                                 hreadyout_o,
    output logic                                 hresp_o,
    output logic [31:0]                          hrdata_o
);
    import tss_fault_pkg::*;

    localparam int  NUM_SEGS = NUM_DATA + 3;
    localparam logic [2:0] LAST_SEG = 3'(NUM_SEGS - 1);

    typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_COMMIT, ST_LOAD, ST_CHECK} state_t;

    function automatic logic beyond(input logic [15:0] sel, input logic [31:0] lim,
                                    input logic upper);
        logic [31:0] top;
        top = {16'h0000, sel[15:3], 3'h7} + (upper ? 32'h0000_0008 : 32'h0000_0000);
        return top > lim;
    endfunction

    function automatic logic is_null(input logic [15:0] sel);
        return sel[15:2] == 14'h0000;
    endfunction

    function automatic logic [15:0] err_of(input logic [15:0] sel, input logic outside_event_flag);
        return {sel[15:2], 1'b0, outside_event_flag};
    endfunction

    state_t           state_r;
    state_t           state_nxt;
    task_req_t        req_r;
    seg_desc_t [NUM_SEGS-1:0] segs_r;
    logic [2:0]       idx_r;
    logic             gp_pend_r;
    logic [31:0]      ctrl_r;
    logic [15:0]      last_err_r;
    logic [7:0]       last_vec_r;
    logic             last_ctx_r;
    logic [15:0]      count_r;
    logic             busy_r;
    logic             done_r;
    logic             tr_load_r;
    logic             link_write_r;
    logic             seg_load_r;
    logic [2:0]       seg_idx_r;
    logic             fault_valid_r;
    fault_rec_t       fault_r;
    logic [31:0]      hrdata_r;
    logic             wr_pend_r;
    logic [31:0]      wr_addr_r;
    logic             hready_r;
    logic             hresp_r;

    // pre-commit checks, all reported against the task segment selector
    wire is_ltr     = req_r.op == OP_LOAD_TR;
    wire is_nested_return_instr    = req_r.op == OP_NESTED_RET;
    wire is_priv    = req_r.op == OP_PRIV_CALL;
    wire is_linked  = (req_r.op == OP_CALL) || (req_r.op == OP_EXCEPTION);
    wire tss_is32   = req_r.tss_type[3];
    wire tss_avail  = (req_r.tss_type == `TYPE_AVAIL_32) ||
                      (!req_r.long_mode && req_r.tss_type == `TYPE_AVAIL_16);
    wire tss_busy   = (req_r.tss_type == `TYPE_BUSY_32) || (req_r.tss_type == `TYPE_BUSY_16);
    wire lim_short  = req_r.tss_limit < (tss_is32 ? `TSS32_MIN_LIMIT : `TSS16_MIN_LIMIT);
    wire sel_null   = is_null(req_r.tss_sel);
    wire sel_ti     = req_r.tss_sel[2];
    wire gdt_over   = beyond(req_r.tss_sel, req_r.gdt_limit, req_r.long_mode);
    wire long_bad   = req_r.long_mode && ((req_r.tss_type == `TYPE_AVAIL_16) ||
                      (req_r.upper_type != `UPPER_TYPE_OK) || !req_r.base_canonical);
    wire nested_return_instr_bad   = sel_ti || gdt_over || !tss_busy || sel_null ||
                      req_r.link_load_fault;
    wire write_bad  = gdt_over || !req_r.new_desc_wr || req_r.old_store_fault ||
                      (!is_linked && !req_r.old_desc_wr) ||
                      (is_linked && !req_r.link_wr);
    wire lock_bad   = sel_null || sel_ti || !tss_avail;
    wire ltr_bad    = sel_null || sel_ti || gdt_over || !tss_avail;
    wire pre_fail   = is_priv ? req_r.stack_load_fault :
                      is_ltr  ? (ltr_bad || long_bad || lim_short) :
                      is_nested_return_instr ? (nested_return_instr_bad || lim_short || write_bad || long_bad) :
                                (lim_short || write_bad || lock_bad || long_bad);

    // post-commit checks on the loaded segment images
    seg_desc_t cur;
    assign cur = segs_r[idx_r];
    wire [1:0] current_privilege       = segs_r[`SEG_CODE].sel[1:0];
    wire       cur_null  = is_null(cur.sel);
    wire       cur_over  = beyond(cur.sel, cur.table_limit, 1'b0);
    wire       cur_code  = cur.s && cur.typ[3];
    wire       nonconf   = cur_code && !cur.typ[2];
    wire ldt_bad  = !cur_null && (cur.sel[2] || cur_over || cur.s ||
                    cur.typ != `TYPE_LDT || !cur.present);
    wire ss_bad   = cur_over || cur_null || !cur.s || cur.typ[3] || !cur.typ[1] ||
                    cur.descriptor_privilege != current_privilege || cur.sel[1:0] != current_privilege;
    wire cs_bad   = cur_over || cur_null || !cur_code ||
                    (nonconf && cur.descriptor_privilege != current_privilege) || (!nonconf && cur.descriptor_privilege > current_privilege);
    wire ds_bad   = !cur_null && (cur_over || !cur.s || (cur.typ[3] && !cur.typ[1]) ||
                    (nonconf && (cur.sel[1:0] > cur.descriptor_privilege || current_privilege > cur.descriptor_privilege)));
    wire seg_fail = (idx_r == `SEG_LDT)   ? ldt_bad :
                    (idx_r == `SEG_STACK) ? ss_bad  :
                    (idx_r == `SEG_CODE)  ? cs_bad  : ds_bad;

    wire check_en  = ctrl_r[`CTRL_EN_BIT];
    wire take_req  = state_r == ST_IDLE && req_valid_i && !gp_pend_r;
    wire take_gp   = state_r == ST_IDLE && gp_pend_r;
    wire pre_fault = state_r == ST_PRE && pre_fail && check_en;
    wire seg_fault = state_r == ST_CHECK && seg_fail && check_en;
    wire any_fault = pre_fault || seg_fault || take_gp;
    wire finish    = (state_r == ST_PRE && (is_ltr || is_priv || pre_fault)) ||
                     (state_r == ST_CHECK && (seg_fault || idx_r == LAST_SEG));

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:   if (take_req) state_nxt = ST_PRE;
            ST_PRE:    if (finish) state_nxt = ST_IDLE;
                       else state_nxt = ST_COMMIT;
            ST_COMMIT: state_nxt = ST_LOAD;
            ST_LOAD:   if (idx_r == LAST_SEG) state_nxt = ST_CHECK;
            ST_CHECK:  if (finish) state_nxt = ST_IDLE;
            default:   state_nxt = ST_IDLE;
        endcase
    end

    // the fault record; only the first failing check ever reaches it
    wire fault_rec_t rec_nxt;
    assign rec_nxt.vector      = take_gp ? `VEC_GEN_PROT : `VEC_INVALID_TASK;
    assign rec_nxt.err_code    = take_gp ? 16'h0000 :
                                 err_of(pre_fault ? req_r.tss_sel : cur.sel,
                                        req_r.outside_event);
    assign rec_nxt.new_ctx     = seg_fault;
    // protection fault is a fault class too, so both kinds restart
    assign rec_nxt.restartable = 1'b1;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            req_r   <= '0;
            segs_r  <= '0;
            idx_r   <= 3'h0;
        end else begin
            state_r <= state_nxt;
            if (take_req) begin
                req_r  <= req_i;
                segs_r <= segs_i;
            end
            // park at zero on finish so the index never walks past the last image
            if (finish || state_r == ST_COMMIT || (state_r == ST_LOAD && idx_r == LAST_SEG))
                idx_r <= 3'h0;
            else if (state_r == ST_LOAD || state_r == ST_CHECK)
                idx_r <= idx_r + 3'h1;
        end
    end

    // overrun from the transfer path; set wins over the service clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            gp_pend_r <= 1'b0;
        else if (overrun_i)
            gp_pend_r <= 1'b1;
        else if (take_gp)
            gp_pend_r <= 1'b0;
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_r        <= 1'b0;
            done_r        <= 1'b0;
            tr_load_r     <= 1'b0;
            link_write_r  <= 1'b0;
            seg_load_r    <= 1'b0;
            seg_idx_r     <= 3'h0;
            fault_valid_r <= 1'b0;
            fault_r       <= '0;
        end else begin
            busy_r        <= state_nxt != ST_IDLE;
            done_r        <= finish;
            tr_load_r     <= state_r == ST_COMMIT;
            link_write_r  <= state_r == ST_COMMIT && is_linked;
            seg_load_r    <= state_r == ST_LOAD;
            seg_idx_r     <= idx_r;
            fault_valid_r <= any_fault;
            if (any_fault)
                fault_r <= rec_nxt;
        end
    end

    // status capture
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_err_r <= 16'h0000;
            last_vec_r <= 8'h00;
            last_ctx_r <= 1'b0;
            count_r    <= 16'h0000;
        end else if (any_fault) begin
            last_err_r <= rec_nxt.err_code;
            last_vec_r <= rec_nxt.vector;
            last_ctx_r <= rec_nxt.new_ctx;
            count_r    <= count_r + 16'h0001;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY, write lands in data phase
    wire addr_ok  = hsel_i && htrans_i[1] && hready_i;
    wire rd_take  = addr_ok && !hwrite_i;
    wire wr_take  = addr_ok && hwrite_i;
    wire [31:0] status_word = {7'h00, last_ctx_r, last_vec_r, last_err_r};
    wire [31:0] rd_word = (haddr_i == `REG_CTRL_OFS)   ? ctrl_r :
                          (haddr_i == `REG_STATUS_OFS) ? status_word :
                          (haddr_i == `REG_COUNT_OFS)  ? {16'h0000, count_r} : 32'h0000_0000;

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 32'h0000_0000;
            hrdata_r  <= 32'h0000_0000;
            ctrl_r    <= `CTRL_RST;
            hready_r  <= 1'b1;
            hresp_r   <= 1'b0;
        end else begin
            hready_r  <= 1'b1;
            hresp_r   <= 1'b0;
            wr_pend_r <= wr_take;
            if (wr_take)
                wr_addr_r <= haddr_i;
            if (rd_take)
                hrdata_r <= rd_word;
            if (wr_pend_r && wr_addr_r == `REG_CTRL_OFS)
                ctrl_r <= {31'h0000_0000, hwdata_i[`CTRL_EN_BIT]};
        end
    end

    assign busy_o        = busy_r;
    assign done_o        = done_r;
    assign tr_load_o     = tr_load_r;
    assign link_write_o  = link_write_r;
    assign seg_load_o    = seg_load_r;
    assign seg_idx_o     = seg_idx_r;
    assign fault_valid_o = fault_valid_r;
    assign fault_o       = fault_r;
    assign hreadyout_o   = hready_r;
    assign hresp_o       = hresp_r;
    assign hrdata_o      = hrdata_r;

    // checks on the design's own behaviour
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_pre_vector: assert property (pre_fault |=> fault_valid_o && fault_o.vector == 8'h0A)
        else $error("pre-commit fault not on vector 10");
    a_pre_old_ctx: assert property (pre_fault |=> !fault_o.new_ctx)
        else $error("pre-commit fault marked new context");
    a_post_new_ctx: assert property (seg_fault |=> fault_o.new_ctx && fault_o.restartable)
        else $error("post-commit fault not in new context");
    a_short_limit: assert property (state_r == ST_PRE && lim_short
                                    && !is_priv && check_en |=> fault_valid_o)
        else $error("short segment limit not faulted");
    a_ltr_null: assert property (state_r == ST_PRE && is_ltr && sel_null && check_en
                                 |=> fault_valid_o && fault_o.err_code[15:3] == 13'h0)
        else $error("null task register load not faulted");
    a_gp_vector: assert property (take_gp |=> fault_valid_o && fault_o.vector == 8'h0D
                                  && fault_o.err_code == 16'h0000)
        else $error("overrun not reported as vector 13");
    a_no_overrun_vec: assert property (fault_valid_o |-> fault_o.vector != 8'h09)
        else $error("reserved overrun vector raised");
    a_commit_order: assert property (state_r == ST_COMMIT |=> tr_load_o ##1 seg_load_o)
        else $error("task register not loaded before segments");
    a_all_loaded: assert property (state_r == ST_COMMIT |=> ##1 seg_load_o [*7])
        else $error("segment loads not contiguous");
    a_load_index: assert property (seg_load_o |=> !seg_load_o ||
                                   seg_idx_o == $past(seg_idx_o) + 3'h1)
        else $error("segment load index out of order");
    // an overrun served right after a task fault is a separate event
    a_single_fault: assert property (fault_valid_o |=>
                                     !(fault_valid_o && fault_o.vector == 8'h0A))
        else $error("more than one fault per request");
    a_ext_flag: assert property (pre_fault |=>
                                 fault_o.err_code[0] == $past(req_r.outside_event))
        else $error("outside event flag not carried");
    a_link_linked: assert property (link_write_o |-> tr_load_o && is_linked)
        else $error("link write without linked switch");

    c_pre_fault: cover property (pre_fault);
    c_post_fault: cover property (seg_fault);
    c_clean_switch: cover property (state_r == ST_CHECK && idx_r == LAST_SEG && !seg_fail);
    c_overrun: cover property (take_gp);

endmodule : tss_fault_unit

`default_nettype wire

//--- dv/dispatch_model.sv
/*
 * Exception dispatch model: gathers each outcome of the fault unit into
 * one record (fault, commit, back-link write, segment loads).
 * Assumes the unit's pulse outputs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module dispatch_model (
    // from the unit
    input  wire logic                     clock_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     done_i,
    input  wire logic                     fault_valid_i,
    input  wire tss_fault_pkg::fault_rec_t fault_i,
    input  wire logic                     tr_load_i,
    input  wire logic                     link_write_i,
    input  wire logic                     seg_load_i,
    // one outcome record
    output logic                          ev_valid_o,
    output logic                          ev_fault_o,
    output tss_fault_pkg::fault_rec_t     ev_rec_o,
    output logic [4:0]                    ev_info_o
);
    import tss_fault_pkg::*;

    logic       cm_r;
    logic       lk_r;
    logic [2:0] lds_r;
    wire        ev_w = done_i | fault_valid_i;

    // handler entered as a task of its own: record taken whole, old state unused
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {cm_r, lk_r, lds_r, ev_valid_o, ev_fault_o, ev_info_o} <= '0;
            ev_rec_o <= '0;
        end else begin
            ev_valid_o <= ev_w;
            ev_fault_o <= fault_valid_i;
            ev_rec_o   <= fault_i;
            ev_info_o  <= {cm_r | tr_load_i, lk_r | link_write_i, lds_r + 3'(seg_load_i)};
            cm_r       <= ev_w ? 1'b0 : (cm_r | tr_load_i);
            lk_r       <= ev_w ? 1'b0 : (lk_r | link_write_i);
            lds_r      <= ev_w ? 3'h0 : (lds_r + 3'(seg_load_i));
        end
    end
endmodule // dispatch_model

`default_nettype wire

//--- dv/tb_top.sv
/*
 * Bench for the task-state fault unit: switch checks, overrun, registers.
 * Assumes the unit, its package and the dispatch model compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tss_fault_defs.svh"

module tb_top;
    import tss_fault_pkg::*;

    typedef struct {logic f; logic [7:0] v; logic [15:0] e; logic n; logic m; logic [4:0] i;} expect_t;
    expect_t         exp_q[$];
    expect_t         mx;
    expect_t         last_x;
    int              mismatches = 0;
    int              check_count = 0;
    int              fail_at[32] = '{-1, 7, 7, -1, 7, 7, 7, 7, 7, 7, 7, 0, 1, 1, 2, 2,
                                     4, 5, 7, 7, 7, -1, -1, 7, 7, 7, 7, 7, 7, 1, 7, -1};
    logic            clock_i = 1'b0;
    logic            sys_rst_i = 1'b1;
    logic            req_valid_i = 1'b0;
    logic            overrun_i = 1'b0;
    task_req_t       req_i = '0;
    seg_desc_t [6:0] segs_i = '0;
    logic            hsel_i = 1'b0;
    logic            hwrite_i = 1'b0;
    logic [1:0]      htrans_i = 2'h0;
    logic [2:0]      hsize_i = 3'h2;
    logic [31:0]     haddr_i = 32'h0;
    logic [31:0]     hwdata_i = 32'h0;
    logic [31:0]     hrdata_o;
    logic [31:0]     rd;
    logic            hreadyout_o, hresp_o, busy_o, done_o, tr_load_o, link_write_o;
    logic            seg_load_o, fault_valid_o, ev_valid_o, ev_fault_o;
    logic [2:0]      seg_idx_o;
    logic [4:0]      ev_info_o;
    fault_rec_t      fault_o;
    fault_rec_t      ev_rec_o;

    tss_fault_unit tss_fault_unit_i (.clock_i, .sys_rst_i, .req_valid_i, .req_i, .segs_i,
        .overrun_i, .busy_o, .done_o, .tr_load_o, .link_write_o, .seg_load_o, .seg_idx_o,
        .fault_valid_o, .fault_o, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o);
    dispatch_model dispatch_model_i (.clock_i, .sys_rst_i, .done_i(done_o),
        .fault_valid_i(fault_valid_o), .fault_i(fault_o), .tr_load_i(tr_load_o),
        .link_write_i(link_write_o), .seg_load_i(seg_load_o), .ev_valid_o, .ev_fault_o,
        .ev_rec_o, .ev_info_o);

    initial begin
        forever #10 clock_i = ~clock_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] want, input string what);
        check_count++;
        if (got !== want) begin
            mismatches++;
            $display("BAD %0t %s got %h want %h", $time, what, got, want);
        end
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // outcome watcher: oldest note against each record
    always @(posedge clock_i) begin
        if (ev_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0, "outcome without request");
            end else begin
                mx = exp_q.pop_front();
                chk(32'(ev_fault_o), 32'(mx.f), "fault flag");
                if (mx.f) chk(32'({ev_rec_o.vector, ev_rec_o.err_code}), 32'({mx.v, mx.e}), "code");
                if (mx.f) chk(32'({ev_rec_o.new_ctx, ev_rec_o.restartable}), 32'({mx.n, 1'b1}), "ctx");
                if (mx.m) chk(32'(ev_info_o), 32'(mx.i), "commit and loads");
            end
        end
    end

    task automatic run(input task_req_t r, input seg_desc_t [6:0] s, input expect_t x, input bit ov);
        int n;
        exp_q.push_back(x);
        req_valid_i <= !ov;
        overrun_i <= ov;
        req_i <= r;
        segs_i <= s;
        @(posedge clock_i);
        req_valid_i <= 1'b0;
        overrun_i <= 1'b0;
        @(posedge clock_i);
        chk(32'(busy_o), 32'(!ov), "busy after take");
        for (n = 0; n < 40 && exp_q.size() != 0; n++) @(posedge clock_i);
        if (exp_q.size() != 0) begin
            chk(32'h1, 32'h0, "no outcome");
            exp_q.delete();
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= wr;
        // no wait count assumed: only the watchdog ends a stuck wait
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do @(posedge clock_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
        chk(32'(hresp_o), 32'h0, "response");
    endtask

    function automatic seg_desc_t sd(logic [15:0] sel, logic s, logic [3:0] t);
        return '{sel: sel, s: s, typ: t, descriptor_privilege: 2'h0, present: 1'b1, table_limit: 32'h0000_FFFF};
    endfunction

    task automatic scen(input int k);
        task_req_t       r;
        seg_desc_t [6:0] s;
        int              w;
        logic [15:0]     sel;
        r = '{op: OP_CALL, tss_sel: 16'h0028, tss_limit: `TSS32_MIN_LIMIT,
              upper_type: `UPPER_TYPE_OK, base_canonical: 1'b1, gdt_limit: 32'h0000_FFFF,
              new_desc_wr: 1'b1, old_desc_wr: 1'b1, link_wr: 1'b1, default: 1'b0};
        r.outside_event = 1'($urandom);
        s[0] = sd(16'h0030, 1'b0, `TYPE_LDT);
        s[1] = sd(16'h0010, 1'b1, 4'h3);
        s[2] = sd(16'h0008, 1'b1, 4'hB);
        for (int j = 3; j < 7; j++) s[j] = sd(16'($urandom_range(3, 900) << 3), 1'b1, 4'h3);
        if (k inside {[22:27], 30}) r.op = OP_LOAD_TR;
        if (k inside {[18:21]}) r.op = OP_NESTED_RET;
        if (k inside {8, 29}) r.op = OP_EXCEPTION;
        if (k == 7) r.op = OP_JUMP;
        if (k == 28) r.op = OP_PRIV_CALL;
        r.long_mode = k inside {[25:27], 30};
        // nested returns 19 to 21 start from a busy target so 19 and 20 trip only their own check and 21 passes clean
        r.tss_type = k inside {2, 3, 25} ? `TYPE_AVAIL_16 :
                     k inside {[19:21]} ? `TYPE_BUSY_32 : `TYPE_AVAIL_32;
        case (k)
            1: r.tss_limit = 32'h0000_0066;
            2: r.tss_limit = 32'h0000_002B;
            3: r.tss_limit = 32'h0000_002C;
            4: r.new_desc_wr = 1'b0;
            5: r.gdt_limit = 32'h0000_0020;
            6: r.old_store_fault = 1'b1;
            7: r.old_desc_wr = 1'b0;
            8: r.link_wr = 1'b0;
            9, 24: r.tss_type = `TYPE_BUSY_32;
            10: r.tss_sel = 16'h002C;
            11: s[0].present = 1'b0;
            12, 29: s[1].descriptor_privilege = 2'h1;
            13: s[1].sel = 16'h0000;
            14: s[2].typ = 4'h3;
            15: s[2].descriptor_privilege = 2'h2;
            16: s[4].table_limit = 32'h0000_0000;
            17: s[5].typ = 4'h9;
            18: r.tss_type = `TYPE_AVAIL_32;
            19: r.link_load_fault = 1'b1;
            20, 23: r.tss_sel = 16'h0000;
            26: r.upper_type = 5'h01;
            27: r.base_canonical = 1'b0;
            28: r.stack_load_fault = 1'b1;
            30: r.gdt_limit = 32'h0000_002F;
            31: r.tss_limit = 32'h0000_0010;
            default: ;
        endcase
        if (k == 29) s[2].typ = 4'h3;
        if (k == 29) r.outside_event = 1'b1;
        w = fail_at[k];
        sel = (w == 7) ? r.tss_sel : (w >= 0) ? s[w[2:0]].sel : 16'h0000;
        last_x = '{w >= 0, `VEC_INVALID_TASK, {sel[15:2], 1'b0, r.outside_event}, w >= 0 && w < 7,
                   r.op inside {OP_JUMP, OP_CALL, OP_EXCEPTION, OP_NESTED_RET},
                   {w != 7, w != 7 && r.op inside {OP_CALL, OP_EXCEPTION}, (w != 7) ? 3'h7 : 3'h0}};
        run(r, s, last_x, 1'b0);
    endtask

    initial begin
        void'($urandom(6));
        repeat (3) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        ahb(1'b0, `REG_CTRL_OFS, 32'h0000_0000);
        chk(rd, `CTRL_RST, "ctrl reset value");
        for (int k = 0; k < 31; k++) scen(k);
        ahb(1'b0, `REG_STATUS_OFS, 32'h0000_0000);
        chk(rd, {7'h00, last_x.n, last_x.v, last_x.e}, "status");
        ahb(1'b1, `REG_COUNT_OFS, 32'h0000_0000);
        ahb(1'b0, `REG_COUNT_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_001B, "count after read-only write");
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk(rd, 32'h0000_0000, "unmapped read");
        // checking off: a short segment must pass untouched
        ahb(1'b1, `REG_CTRL_OFS, 32'h0000_0000);
        scen(31);
        ahb(1'b1, `REG_CTRL_OFS, `CTRL_RST);
        run(req_i, segs_i, '{1'b1, `VEC_GEN_PROT, 16'h0000, 1'b0, 1'b0, 5'h00}, 1'b1);
        tally_and_finish();
    end

    // hang guard, far above the expected few hundred cycles
    initial begin
        repeat (5000) @(posedge clock_i);
        mismatches++;
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
